// File: bench/clk_seq_asserts.sv
// port assertions for the clock set-up sequencer
module clk_seq_asserts #(
  parameter int unsigned REF_UP_CNT = 50,
  parameter int unsigned MASTER_LOCK_CNT = 80,
  parameter int unsigned SLAVE_LOCK_CNT = 60
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic master_clock_in_i,
  input wire logic power_down_reset_n_i,
  input wire logic master_slave_select_i,
  input wire logic [1:0] output_clock_ratio_select_i,
  input wire logic reference_power_enable_i,
  input wire logic master_clock_out_enable_i,
  input wire logic pll_power_enable_i,
  input wire logic serial_bit_clock_o,
  input wire logic serial_bit_clock_oe_o,
  input wire logic frame_channel_clock_o,
  input wire logic frame_channel_clock_oe_o,
  input wire logic master_clock_out_o,
  input wire logic reference_ready_o,
  input wire logic pll_locked_o,
  input wire logic normal_operation_o
);
  logic [21:0] ref_ff, pll_ff, nxt_ref, nxt_pll;
  // cycles that the reference and PLL power enables have stood high
  always_comb
  begin
    nxt_ref = reference_power_enable_i ? ref_ff + 22'h1 : 22'h0;
    nxt_pll = pll_power_enable_i ? pll_ff + 22'h1 : 22'h0;
  end
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ref_ff <= 22'h0;
      pll_ff <= 22'h0;
    end
    else
    begin
      ref_ff <= nxt_ref;
      pll_ff <= nxt_pll;
    end
  end
  ref_up_time_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(reference_ready_o) |-> ref_ff >= REF_UP_CNT + 1 && ref_ff <= REF_UP_CNT + 3)
    else $error("reference ready at wrong time");
  ref_drop_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!reference_power_enable_i) [*3] |-> !reference_ready_o && !pll_locked_o)
    else $error("status kept without reference power");
  lock_time_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(pll_locked_o) |-> pll_ff > (master_slave_select_i ? MASTER_LOCK_CNT : SLAVE_LOCK_CNT))
    else $error("lock reported too early");
  normal_op_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    normal_operation_o == pll_locked_o && (reference_ready_o || !pll_locked_o))
    else $error("normal operation without lock");
  pins_float_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (!master_slave_select_i) [*4] |-> !serial_bit_clock_oe_o && !frame_channel_clock_oe_o)
    else $error("clock pins driven in slave mode");
  pins_drive_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (master_slave_select_i && power_down_reset_n_i) [*4] |-> serial_bit_clock_oe_o
    && frame_channel_clock_oe_o) else $error("clock pins not driven in master mode");
  lock_hold_a: assert property (@(posedge master_clock_in_i) disable iff (!resetn_i)
    (master_slave_select_i && !pll_locked_o) [*4] |-> serial_bit_clock_o
    && !frame_channel_clock_o) else $error("clock levels wrong while locking");
  bit_run_a: assert property (@(posedge master_clock_in_i) disable iff (!resetn_i)
    (master_slave_select_i && pll_locked_o) [*8] |->
    serial_bit_clock_o != $past(serial_bit_clock_o, 2)) else $error("bit clock not running");
  mco_run_a: assert property (@(posedge master_clock_in_i) disable iff (!resetn_i)
    (master_clock_out_enable_i && pll_locked_o && output_clock_ratio_select_i == 2'h1) [*8]
    |-> master_clock_out_o != $past(master_clock_out_o, 2)) else $error("bad master out");
  mco_off_a: assert property (@(posedge master_clock_in_i) disable iff (!resetn_i)
    (!master_clock_out_enable_i) [*5] |-> !master_clock_out_o)
    else $error("master out active while disabled");
endmodule : clk_seq_asserts

bind codec_clock_setup_sequencer clk_seq_asserts #(.REF_UP_CNT(REF_UP_CNT),
  .MASTER_LOCK_CNT(MASTER_LOCK_CNT), .SLAVE_LOCK_CNT(SLAVE_LOCK_CNT)) chk (.clk_i,
  .resetn_i, .master_clock_in_i, .power_down_reset_n_i, .master_slave_select_i,
  .output_clock_ratio_select_i, .reference_power_enable_i, .master_clock_out_enable_i,
  .pll_power_enable_i, .serial_bit_clock_o, .serial_bit_clock_oe_o, .frame_channel_clock_o,
  .frame_channel_clock_oe_o, .master_clock_out_o, .reference_ready_o, .pll_locked_o,
  .normal_operation_o);

// File: bench/clock_peer.sv
// far-side model: master clock source and serial clock peer with pull-ups
module clock_peer (
  input wire logic bit_run_i,
  input wire logic bit_dut_i,
  input wire logic bit_oe_i,
  input wire logic frame_dut_i,
  input wire logic frame_oe_i,
  output logic mclk_o,
  output logic bit_line_o,
  output logic frame_line_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic bit_ff = 1'b1;
  logic [5:0] slot_ff = 6'h0;
  // master clock runs free while the codec is powered
  initial
  begin
    mclk_o = 1'b0;
    #5;
    forever #16 mclk_o = ~mclk_o;
  end
  // bit clock reference runs only while frames are requested
  always
  begin
    #32;
    bit_ff = bit_run_i ? ~bit_ff : 1'b1;
    slot_ff = slot_ff + {5'h0, bit_run_i & bit_ff};
  end
  // device drives when enabled, else the peer, else the pull-up holds high
  assign bit_line_o = bit_oe_i ? bit_dut_i : (bit_run_i ? bit_ff : 1'b1);
  assign frame_line_o = frame_oe_i ? frame_dut_i : (bit_run_i ? slot_ff[4] : 1'b1);
endmodule : clock_peer

// File: bench/tb_top.sv
// self-checking bench for the clock set-up sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int REF_N = 50;
  localparam int MLOCK = 80;
  localparam int SLOCK = 60;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic power_down_reset_n_i = 1'b0;
  logic master_slave_select_i = 1'b1;
  logic [1:0] audio_format_select_i = 2'h1;
  logic bit_clock_rate_select_i = 1'b1;
  logic [3:0] pll_reference_select_i = 4'h3;
  logic [3:0] sample_rate_select_i = 4'h8;
  logic speed_select_i = 1'b1;
  logic [1:0] output_clock_ratio_select_i = 2'h1;
  logic reference_power_enable_i = 1'b0;
  logic master_clock_out_enable_i = 1'b1;
  logic pll_power_enable_i = 1'b0;
  logic bit_run = 1'b0;
  wire logic master_clock_in_i, serial_bit_clock_i, frame_channel_clock_i;
  logic serial_bit_clock_o, serial_bit_clock_oe_o, frame_channel_clock_o;
  logic frame_channel_clock_oe_o, master_clock_out_o, reference_ready_o;
  logic pll_locked_o, normal_operation_o;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  codec_clock_setup_sequencer #(.REF_UP_CNT(REF_N), .MASTER_LOCK_CNT(MLOCK),
    .SLAVE_LOCK_CNT(SLOCK)) uut (.clk_i, .resetn_i, .master_clock_in_i,
    .power_down_reset_n_i, .master_slave_select_i, .audio_format_select_i,
    .bit_clock_rate_select_i, .pll_reference_select_i, .sample_rate_select_i, .speed_select_i,
    .output_clock_ratio_select_i, .reference_power_enable_i, .master_clock_out_enable_i,
    .pll_power_enable_i, .serial_bit_clock_i, .frame_channel_clock_i, .serial_bit_clock_o,
    .serial_bit_clock_oe_o, .frame_channel_clock_o, .frame_channel_clock_oe_o,
    .master_clock_out_o, .reference_ready_o, .pll_locked_o, .normal_operation_o);
  clock_peer peer (.bit_run_i(bit_run), .bit_dut_i(serial_bit_clock_o),
    .bit_oe_i(serial_bit_clock_oe_o), .frame_dut_i(frame_channel_clock_o),
    .frame_oe_i(frame_channel_clock_oe_o), .mclk_o(master_clock_in_i),
    .bit_line_o(serial_bit_clock_i), .frame_line_o(frame_channel_clock_i));
  // system clock and hang guard
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // cycles until ready (k=0) or lock (k=1) shows
  task automatic wait_flag(input int k, output int cnt);
    cnt = 0;
    while ((k == 0 ? reference_ready_o : pll_locked_o) !== 1'b1 && cnt < 2000)
    begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
  endtask : wait_flag
  // bit clock rises within one frame clock half
  task automatic frame_bits(output int nb);
    logic f;
    logic b;
    int ch;
    nb = 0;
    ch = 0;
    f = frame_channel_clock_i;
    b = serial_bit_clock_i;
    for (int t = 0; t < 3000 && ch < 2; t++)
    begin
      @(posedge clk_i);
      #1;
      nb += (ch == 1 && !b && serial_bit_clock_i) ? 1 : 0;
      ch += (frame_channel_clock_i !== f) ? 1 : 0;
      f = frame_channel_clock_i;
      b = serial_bit_clock_i;
    end
  endtask : frame_bits
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // master mode, then slave mode with the bit clock reference
  initial
  begin
    repeat (6) @(posedge master_clock_in_i);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    power_down_reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("pins driven", 1'b1, serial_bit_clock_oe_o & frame_channel_clock_oe_o);
    bit_clock_rate_select_i <= 1'b1;
    output_clock_ratio_select_i <= 2'h1;
    master_clock_out_enable_i <= 1'b1;
    reference_power_enable_i <= 1'b1;
    pll_power_enable_i <= 1'b1;
    wait_flag(0, n);
    check("ref up cycles", REF_N + 1, n);
    repeat (MLOCK + 30) @(posedge clk_i);
    check("early pll ignored", 1'b0, pll_locked_o);
    check("bit held", 1'b1, serial_bit_clock_i);
    check("frame held", 1'b0, frame_channel_clock_i);
    pll_power_enable_i <= 1'b0;
    @(posedge clk_i);
    pll_power_enable_i <= 1'b1;
    wait_flag(1, n);
    check("master lock", 1'b1, n > MLOCK && n <= MLOCK + 32);
    check("normal", 1'b1, normal_operation_o);
    frame_bits(n);
    check("bits per half", 32'd32, n);
    // stop the PLL, pick 32fs with the master out unused, then relock
    @(posedge clk_i);
    pll_power_enable_i <= 1'b0;
    bit_clock_rate_select_i <= 1'b0;
    master_clock_out_enable_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    check("bit held again", 1'b1, serial_bit_clock_i);
    pll_power_enable_i <= 1'b1;
    wait_flag(1, n);
    check("master relock", 1'b1, n > MLOCK && n <= MLOCK + 32);
    frame_bits(n);
    check("bits per half 32fs", 32'd16, n);
    check("master out unused", 1'b0, master_clock_out_o);
    $display("master mode test done");
    @(posedge clk_i);
    power_down_reset_n_i <= 1'b0;
    reference_power_enable_i <= 1'b0;
    pll_power_enable_i <= 1'b0;
    master_slave_select_i <= 1'b0;
    master_clock_out_enable_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    check("reset clears lock", 1'b0, pll_locked_o);
    power_down_reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("pins released", 2'h0, {serial_bit_clock_oe_o, frame_channel_clock_oe_o});
    audio_format_select_i <= 2'h0;
    sample_rate_select_i <= 4'h7;
    reference_power_enable_i <= 1'b1;
    wait_flag(0, n);
    check("ref up again", REF_N + 1, n);
    @(posedge clk_i);
    pll_power_enable_i <= 1'b1;
    repeat (SLOCK + 30) @(posedge clk_i);
    check("no lock without ref", 1'b0, pll_locked_o);
    bit_run <= 1'b1;
    wait_flag(1, n);
    check("slave lock", 1'b1, n > SLOCK && n <= SLOCK + 32);
    check("slave normal", 1'b1, normal_operation_o);
    bit_run <= 1'b0;
    repeat (100) @(posedge clk_i);
    check("lock lost", 1'b0, normal_operation_o);
    $display("slave mode test done");
    close_out();
  end
endmodule : tb_top

// File: hw/clk_link_if.sv
// carrier between the sequencer and its link-clock generator
interface clk_link_if;
  logic run;
  logic mco_en;
  logic locked;
  logic rate_64fs;
  logic [1:0] ratio_sel;
  logic alive_tgl;
  modport seq (output run, output mco_en, output locked, output rate_64fs,
    output ratio_sel, input alive_tgl);
  modport gen (input run, input mco_en, input locked, input rate_64fs,
    input ratio_sel, output alive_tgl);
endinterface : clk_link_if

// File: hw/clk_seq_pkg.sv
// constants and types for the codec clock set-up sequencer
package clk_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned REF_UP_TIME_NS = 3000000;
  localparam int unsigned MASTER_LOCK_TIME_NS = 10000000;
  localparam int unsigned SLAVE_LOCK_TIME_NS = 2000000;
  localparam int unsigned CLK_LOSS_TIME_NS = 256;
  // longest times round down to whole cycles
  localparam int unsigned REF_UP_CYCLES = REF_UP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned MASTER_LOCK_CYCLES = MASTER_LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SLAVE_LOCK_CYCLES = SLAVE_LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CLK_LOSS_CYCLES = CLK_LOSS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 22;
  localparam int unsigned LOSS_W = 7;
  // link-side dividers: bit and master-out halves in master clock cycles, frame halves in bit clock periods
  localparam logic [1:0] BIT_HALF_DIV = 2'h2;
  localparam logic [5:0] FRAME_HALF_32FS = 6'h10;
  localparam logic [5:0] FRAME_HALF_64FS = 6'h20;
  localparam logic [3:0] MCO_INVALID_HALF = 4'h1;
  localparam logic [3:0] MCO_BASE_HALF = 4'h1;

  typedef enum logic [2:0] {
    ST_DOWN = 3'h0,
    ST_REF_UP = 3'h1,
    ST_IDLE = 3'h3,
    ST_WAIT_CLK = 3'h2,
    ST_LOCKING = 3'h6,
    ST_RUN = 3'h7
  } seq_state_t;
endpackage : clk_seq_pkg

// File: hw/codec_clock_setup_sequencer.sv
// power-up and PLL start sequencer with link clock outputs
module codec_clock_setup_sequencer #(
  parameter int unsigned REF_UP_CNT = clk_seq_pkg::REF_UP_CYCLES,
  parameter int unsigned MASTER_LOCK_CNT = clk_seq_pkg::MASTER_LOCK_CYCLES,
  parameter int unsigned SLAVE_LOCK_CNT = clk_seq_pkg::SLAVE_LOCK_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic master_clock_in_i,
  input wire logic power_down_reset_n_i,
  input wire logic master_slave_select_i,
  input wire logic [1:0] audio_format_select_i,
  input wire logic bit_clock_rate_select_i,
  input wire logic [3:0] pll_reference_select_i,
  input wire logic [3:0] sample_rate_select_i,
  input wire logic speed_select_i,
  input wire logic [1:0] output_clock_ratio_select_i,
  input wire logic reference_power_enable_i,
  input wire logic master_clock_out_enable_i,
  input wire logic pll_power_enable_i,
  input wire logic serial_bit_clock_i,
  input wire logic frame_channel_clock_i,
  output logic serial_bit_clock_o,
  output logic serial_bit_clock_oe_o,
  output logic frame_channel_clock_o,
  output logic frame_channel_clock_oe_o,
  output logic master_clock_out_o,
  output logic reference_ready_o,
  output logic pll_locked_o,
  output logic normal_operation_o
);
  import clk_seq_pkg::*;

  clk_link_if lnk ();

  seq_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [LOSS_W-1:0] loss_ff, nxt_loss;
  logic pdn_meta_ff, pdn_sync_ff;
  logic bck_meta_ff, bck_sync_ff, bck_last_ff;
  logic alive_meta_ff, alive_sync_ff, alive_last_ff;
  logic pll_last_ff;
  logic run_ff, mco_en_ff, locked_ff, ref_ready_ff, normal_ff, drive_ff;
  logic rate_ff;
  logic [1:0] ratio_ff;
  logic nxt_run, nxt_mco_en, nxt_locked, nxt_ref_ready, nxt_normal, nxt_drive;
  logic nxt_rate;
  logic [1:0] nxt_ratio;
  logic ref_edge, ref_present, pll_rise;
  logic [CNT_W-1:0] lock_last;

  // counter end value: a timed interval lasts count cycles
  function automatic logic [CNT_W-1:0] last_cycle(input int unsigned count);
    last_cycle = CNT_W'(count - 1);
  endfunction : last_cycle

  // the power-down and bit clock pins and the link heartbeat pass two flip-flops before use
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pdn_meta_ff <= 1'b0;
      pdn_sync_ff <= 1'b0;
      bck_meta_ff <= 1'b1; // idle level of the pulled-up pin, no false edge
      bck_sync_ff <= 1'b1;
      bck_last_ff <= 1'b1;
      alive_meta_ff <= 1'b0;
      alive_sync_ff <= 1'b0;
      alive_last_ff <= 1'b0;
    end
    else
    begin
      pdn_meta_ff <= power_down_reset_n_i;
      pdn_sync_ff <= pdn_meta_ff;
      bck_meta_ff <= serial_bit_clock_i;
      bck_sync_ff <= bck_meta_ff;
      bck_last_ff <= bck_sync_ff;
      alive_meta_ff <= lnk.alive_tgl;
      alive_sync_ff <= alive_meta_ff;
      alive_last_ff <= alive_sync_ff;
    end
  end

  // reference clock: master clock in master mode, bit clock in slave mode
  assign ref_edge = master_slave_select_i ? (alive_sync_ff ^ alive_last_ff)
                                          : (bck_sync_ff ^ bck_last_ff);
  assign ref_present = (loss_ff != LOSS_W'(CLK_LOSS_CYCLES));
  assign pll_rise = pll_power_enable_i & ~pll_last_ff;
  assign lock_last = master_slave_select_i ? last_cycle(MASTER_LOCK_CNT)
                                           : last_cycle(SLAVE_LOCK_CNT);

  // clock-loss watchdog, cleared by each reference edge
  always_comb
  begin
    nxt_loss = loss_ff;
    if (ref_edge)
      nxt_loss = '0;
    else if (ref_present)
      nxt_loss = loss_ff + LOSS_W'(1);
  end

  // sequence: reference power-up, PLL start, lock, run
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + CNT_W'(1);
    unique case (state_ff)
      ST_DOWN:
      begin
        nxt_cnt = '0;
        if (reference_power_enable_i)
          nxt_state = ST_REF_UP;
      end
      ST_REF_UP:
      begin
        if (cnt_ff == last_cycle(REF_UP_CNT))
          nxt_state = ST_IDLE;
      end
      ST_IDLE:
      begin
        nxt_cnt = '0;
        if (pll_rise)
          nxt_state = ST_WAIT_CLK;
      end
      ST_WAIT_CLK:
      begin
        nxt_cnt = '0;
        if (ref_present)
          nxt_state = ST_LOCKING;
      end
      ST_LOCKING:
      begin
        if (!ref_present)
          nxt_state = ST_WAIT_CLK;
        else if (cnt_ff == lock_last)
          nxt_state = ST_RUN;
      end
      ST_RUN:
      begin
        nxt_cnt = '0;
        if (!ref_present)
          nxt_state = ST_WAIT_CLK;
      end
      default:
      begin
        nxt_cnt = '0;
        nxt_state = ST_DOWN;
      end
    endcase
    // dropping PLL power falls back to idle, dropping reference power to down
    if ((state_ff == ST_WAIT_CLK || state_ff == ST_LOCKING || state_ff == ST_RUN)
        && !pll_power_enable_i)
      nxt_state = ST_IDLE;
    if (!reference_power_enable_i)
      nxt_state = ST_DOWN;
  end

  // sequencer registers; the reset pin clears them synchronously
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_ff <= ST_DOWN;
      cnt_ff <= '0;
      loss_ff <= LOSS_W'(CLK_LOSS_CYCLES);
      pll_last_ff <= 1'b0;
    end
    else if (!pdn_sync_ff)
    begin
      state_ff <= ST_DOWN;
      cnt_ff <= '0;
      loss_ff <= LOSS_W'(CLK_LOSS_CYCLES);
      pll_last_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      loss_ff <= nxt_loss;
      pll_last_ff <= pll_power_enable_i;
    end
  end

  // next status and link control levels, all but rate and ratio cleared while the reset pin is low
  always_comb
  begin
    nxt_ref_ready = 1'b0;
    nxt_locked = 1'b0;
    nxt_normal = 1'b0;
    nxt_run = 1'b0;
    nxt_mco_en = 1'b0;
    nxt_drive = 1'b0;
    nxt_rate = bit_clock_rate_select_i;
    nxt_ratio = output_clock_ratio_select_i;
    if (pdn_sync_ff)
    begin
      nxt_ref_ready = (nxt_state != ST_DOWN) && (nxt_state != ST_REF_UP);
      nxt_locked = (nxt_state == ST_RUN);
      nxt_normal = (nxt_state == ST_RUN);
      nxt_run = (nxt_state == ST_RUN) && master_slave_select_i;
      nxt_mco_en = master_slave_select_i && master_clock_out_enable_i;
      nxt_drive = master_slave_select_i;
    end
  end

  // status and link control registers
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ref_ready_ff <= 1'b0;
      locked_ff <= 1'b0;
      normal_ff <= 1'b0;
      run_ff <= 1'b0;
      mco_en_ff <= 1'b0;
      drive_ff <= 1'b0;
      rate_ff <= 1'b0;
      ratio_ff <= 2'h0;
    end
    else
    begin
      ref_ready_ff <= nxt_ref_ready;
      locked_ff <= nxt_locked;
      normal_ff <= nxt_normal;
      run_ff <= nxt_run;
      mco_en_ff <= nxt_mco_en;
      drive_ff <= nxt_drive;
      rate_ff <= nxt_rate;
      ratio_ff <= nxt_ratio;
    end
  end

  assign lnk.run = run_ff;
  assign lnk.mco_en = mco_en_ff;
  assign lnk.locked = locked_ff;
  assign lnk.rate_64fs = rate_ff;
  assign lnk.ratio_sel = ratio_ff;

  // clock generation on the master clock
  link_clock_gen u_gen (
    .link_clk_i(master_clock_in_i),
    .resetn_i(resetn_i),
    .lnk(lnk.gen),
    .bit_clk_o(serial_bit_clock_o),
    .frame_clk_o(frame_channel_clock_o),
    .mclk_out_o(master_clock_out_o)
  );

  assign serial_bit_clock_oe_o = drive_ff;
  assign frame_channel_clock_oe_o = drive_ff;
  assign reference_ready_o = ref_ready_ff;
  assign pll_locked_o = locked_ff;
  assign normal_operation_o = normal_ff;
endmodule : codec_clock_setup_sequencer

// File: hw/link_clock_gen.sv
// link-domain generator of bit, frame and master output clocks
module link_clock_gen
  import clk_seq_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic resetn_i,
  clk_link_if.gen lnk,
  output logic bit_clk_o,
  output logic frame_clk_o,
  output logic mclk_out_o
);
  logic [1:0] rst_sync_ff;
  logic [5:0] ctl_meta_ff;
  logic [5:0] ctl_sync_ff;
  logic alive_ff;
  logic [1:0] bdiv_ff, nxt_bdiv;
  logic [5:0] fcnt_ff, nxt_fcnt;
  logic [3:0] mcnt_ff, nxt_mcnt;
  logic bit_ff, nxt_bit;
  logic frame_ff, nxt_frame;
  logic mco_ff, nxt_mco;
  logic run, mco_en, locked, rate_64fs;
  logic [1:0] ratio_sel;
  logic [5:0] frame_half;
  logic [3:0] mco_half;

  // local reset release, aligned to the link clock
  always_ff @(posedge link_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  // two-stage capture of the levels coming from the system domain
  always_ff @(posedge link_clk_i or negedge rst_sync_ff[1])
  begin
    if (!rst_sync_ff[1])
    begin
      ctl_meta_ff <= 6'h00;
      ctl_sync_ff <= 6'h00;
      alive_ff <= 1'b0;
    end
    else
    begin
      ctl_meta_ff <= {lnk.ratio_sel, lnk.rate_64fs, lnk.locked, lnk.mco_en, lnk.run};
      ctl_sync_ff <= ctl_meta_ff;
      alive_ff <= ~alive_ff; // heartbeat that shows the master clock runs
    end
  end

  assign {ratio_sel, rate_64fs, locked, mco_en, run} = ctl_sync_ff;
  assign lnk.alive_tgl = alive_ff;
  assign frame_half = rate_64fs ? FRAME_HALF_64FS : FRAME_HALF_32FS;
  assign mco_half = locked ? 4'(MCO_BASE_HALF << ratio_sel) : MCO_INVALID_HALF;

  // next values of the dividers and clock outputs
  always_comb
  begin
    nxt_bdiv = bdiv_ff;
    nxt_fcnt = fcnt_ff;
    nxt_bit = bit_ff;
    nxt_frame = frame_ff;
    nxt_mcnt = mcnt_ff + 4'h1;
    nxt_mco = mco_ff;
    if (!run)
    begin
      nxt_bdiv = 2'h0;
      nxt_fcnt = 6'h00;
      nxt_bit = 1'b1;
      nxt_frame = 1'b0;
    end
    else if (bdiv_ff == BIT_HALF_DIV - 2'h1)
    begin
      nxt_bdiv = 2'h0;
      nxt_bit = ~bit_ff;
      if (bit_ff)
      begin
        // frame clock changes on a bit clock falling edge
        if (fcnt_ff == frame_half - 6'h01)
        begin
          nxt_fcnt = 6'h00;
          nxt_frame = ~frame_ff;
        end
        else
          nxt_fcnt = fcnt_ff + 6'h01;
      end
    end
    else
      nxt_bdiv = bdiv_ff + 2'h1;
    if (!mco_en)
    begin
      nxt_mcnt = 4'h0;
      nxt_mco = 1'b0;
    end
    else if (mcnt_ff >= mco_half - 4'h1)
    begin
      nxt_mcnt = 4'h0;
      nxt_mco = ~mco_ff;
    end
  end

  // registers of the link-side clocks
  always_ff @(posedge link_clk_i or negedge rst_sync_ff[1])
  begin
    if (!rst_sync_ff[1])
    begin
      bdiv_ff <= 2'h0;
      fcnt_ff <= 6'h00;
      mcnt_ff <= 4'h0;
      bit_ff <= 1'b1;
      frame_ff <= 1'b0;
      mco_ff <= 1'b0;
    end
    else
    begin
      bdiv_ff <= nxt_bdiv;
      fcnt_ff <= nxt_fcnt;
      mcnt_ff <= nxt_mcnt;
      bit_ff <= nxt_bit;
      frame_ff <= nxt_frame;
      mco_ff <= nxt_mco;
    end
  end

  assign bit_clk_o = bit_ff;
  assign frame_clk_o = frame_ff;
  assign mclk_out_o = mco_ff;
endmodule : link_clock_gen
